/* File: eeprom_status_pkg.sv */
// Purpose: Shared constants and types for the serial EEPROM status/protect block
// Assumes: System clock 250 MHz; link clock is the host serial clock
// Notes:   Rules carried by the status and protect block
// Function
// RL1 - Eight-bit status register with fixed bit fields
// RL2 - Reserved bits read ones only while busy
// RL3 - Two protect bits select four protection levels
// RL4 - Levels guard C000h, 8000h, whole array upward
// RL5 - Write latch read-only, cleared after power-up
// RL6 - Busy flag read-only, one during internal operation
// RL7 - Opcode 05h shifts status out afterwards
// RL8 - Opcode 06h sets latch at deselection
// RL9 - Host sets latch before every write command
// RL10 - Opcode 04h clears latch regardless of guard pin
// RL11 - Status write changes only lock and protect bits
// RL12 - Lock and protect bits are nonvolatile
// RL13 - Valid status write starts cycle at deselect
// RL14 - During cycle only status read is served; array_write_allowed ignores busy
// RL15 - Cycle completion clears the write latch
// RL16 - Guard pin low with lock refuses writes; the code refuses status writes only, array_write_allowed ignores the pin
// RL17 - Otherwise status writes need only the latch
// RL18 - Lock bit stays set while guard active
// RL19 - Protected addresses never written; others need latch
// RL20 - Opcode bit three is ignored in decode
// RL21 - Guard pin falling mid-command aborts status write
// RL22 - Refused status write changes nothing, no cycle
// RL23 - Cycle length is a parameter, busy exactly that
`default_nettype none

package eeprom_status_pkg;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int WRITE_CYCLE_TIME_US = 4000;
  localparam int WRITE_CYCLE_CYCLES = (WRITE_CYCLE_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);

  localparam logic [7:0] OPCODE_MASK      = 8'hf7;
  localparam logic [7:0] OPC_SET_LATCH    = 8'h06;
  localparam logic [7:0] OPC_CLEAR_LATCH  = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS  = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_READ_ARRAY   = 8'h03;
  localparam logic [7:0] OPC_WRITE_ARRAY  = 8'h02;

  localparam int PIN_LOCK_POS  = 7;
  localparam int PROTECT_HI_POS = 3;
  localparam int PROTECT_LO_POS = 2;

  localparam logic [2:0]  NV_RESET       = 3'h0;
  localparam logic [15:0] LEVEL1_BASE    = 16'hc000;
  localparam logic [15:0] LEVEL2_BASE    = 16'h8000;
  localparam logic [1:0]  BYTE_OPCODE    = 2'h0;
  localparam logic [1:0]  BYTE_DATA      = 2'h1;
  localparam logic [1:0]  BYTE_OVERRUN   = 2'h2;
  localparam logic [2:0]  LAST_BIT       = 3'h7;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_SET_LATCH, CMD_CLEAR_LATCH, CMD_READ_STATUS,
    CMD_WRITE_STATUS, CMD_READ_ARRAY, CMD_WRITE_ARRAY, CMD_INVALID
  } link_cmd_e;

  typedef struct packed {
    link_cmd_e  cmd;
    logic [7:0] data;
    logic       length_ok;
  } frame_s;

  typedef struct packed {
    logic       pin_lock_enable;
    logic [2:0] reserved_bits;
    logic       block_protect_high;
    logic       block_protect_low;
    logic       write_enable_latch;
    logic       ready_busy_flag;
  } status_s;

endpackage

`default_nettype wire

/* File: eeprom_status_protect.sv */
// Purpose: Status register, write latch, block protect and busy timing of an SPI EEPROM
// Assumes: Host uses SPI mode 0/3; reset_n is power-up; nonvolatile image given on nv_load_value
// Notes:   Frame decoding runs on sck; register updates run on clk after deselection
`default_nettype none

module eeprom_status_protect
  import eeprom_status_pkg::*;
#(
  parameter int WRITE_CYCLES = eeprom_status_pkg::WRITE_CYCLE_CYCLES
)(
  input  wire logic        clk,                 // System clock
  input  wire logic        reset_n,             // Power-up reset
  input  wire logic        sck,                 // Host serial clock
  input  wire logic        cs_n,                // Chip select
  input  wire logic        si,                  // Serial data in
  input  wire logic        wp_n,                // Write-guard pin
  output var  logic        so_out,              // Serial data out value
  output var  logic        so_oe,               // Serial data out enable
  input  wire logic [15:0] array_addr,          // Array write address to check
  output var  logic        array_write_allowed, // Address writable now
  input  wire logic [2:0]  nv_load_value,       // Stored lock/protect bits
  output var  logic [2:0]  nv_value             // Lock/protect bits to store
);
  import eeprom_status_pkg::*;

  // Timer is 24 bits wide
  if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << 24))
  begin : g_bad_cycles
    $error("WRITE_CYCLES out of range");
  end

  // Clock domain: pin synchronisers
  logic [2:0] cs_sync;
  logic [2:0] wp_sync;
  logic       cs_stable;
  logic       wp_stable;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs_sync   <= 3'h7;
      wp_sync   <= 3'h7;
      cs_stable <= 1'b1;
      wp_stable <= 1'b1;
    end
    else
    begin
      cs_sync <= {cs_sync[1:0], cs_n};
      wp_sync <= {wp_sync[1:0], wp_n};
      if (cs_sync[1] == cs_sync[2])
        cs_stable <= cs_sync[2];
      if (wp_sync[1] == wp_sync[2])
        wp_stable <= wp_sync[2];
    end
  end

  wire frame_end   = cs_sync[1] & cs_sync[2] & ~cs_stable;
  wire frame_start = ~cs_sync[1] & ~cs_sync[2] & cs_stable;
  wire wp_fall     = ~wp_sync[1] & ~wp_sync[2] & wp_stable;

  // Clock domain: status register and write cycle
  frame_s      frame;
  logic        pin_lock;
  logic [1:0]  protect;
  logic        write_enable_latch;
  logic        busy;
  logic [23:0] timer;
  logic        nv_loaded;
  logic        wp_abort;

  wire hw_protect   = pin_lock & ~wp_stable;                              // RL16 RL17 RL18
  wire take_cmd     = frame_end & ~busy;                                  // RL14
  wire do_set       = take_cmd & (frame.cmd == CMD_SET_LATCH);            // RL8
  wire do_clear     = take_cmd & (frame.cmd == CMD_CLEAR_LATCH);          // RL10
  wire write_ok     = take_cmd & (frame.cmd == CMD_WRITE_STATUS) & frame.length_ok
                      & write_enable_latch & ~hw_protect & ~wp_abort;     // RL13 RL21 RL22
  wire cycle_done   = busy & (timer == 24'h0);
  wire next_write_enable_latch =
    do_set ? 1'b1 : ((do_clear | cycle_done) ? 1'b0 : write_enable_latch);  // RL15

  status_s status_word;
  assign status_word = '{pin_lock_enable: pin_lock, reserved_bits: {3{busy}},   // RL1 RL2
                         block_protect_high: protect[1], block_protect_low: protect[0],
                         write_enable_latch: write_enable_latch,                 // RL5
                         ready_busy_flag: busy};                                 // RL6

  logic addr_protected;
  always_comb
  begin
    unique case (protect)                                                 // RL3 RL4
      2'b00: addr_protected = 1'b0;
      2'b01: addr_protected = (array_addr >= LEVEL1_BASE);
      2'b10: addr_protected = (array_addr >= LEVEL2_BASE);
      2'b11: addr_protected = 1'b1;
    endcase
  end

  // Nonvolatile bits come from the backing store just after power-up
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nv_loaded <= 1'b0;
      pin_lock  <= NV_RESET[2];
      protect   <= NV_RESET[1:0];
    end
    else if (!nv_loaded)
    begin
      nv_loaded <= 1'b1;
      pin_lock  <= nv_load_value[2];                                      // RL12
      protect   <= nv_load_value[1:0];
    end
    else if (write_ok)
    begin
      pin_lock  <= frame.data[PIN_LOCK_POS];                              // RL11
      protect   <= {frame.data[PROTECT_HI_POS], frame.data[PROTECT_LO_POS]};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      write_enable_latch  <= 1'b0;
      busy                <= 1'b0;
      timer               <= 24'h0;
      wp_abort            <= 1'b0;
      array_write_allowed <= 1'b0;
      nv_value            <= NV_RESET;
    end
    else
    begin
      write_enable_latch <= next_write_enable_latch;
      if (write_ok)
      begin
        busy  <= 1'b1;
        timer <= 24'(WRITE_CYCLES - 1);                                   // RL23
      end
      else if (cycle_done)
        busy <= 1'b0;
      else if (busy)
        timer <= timer - 24'h1;
      // Set wins: a fall right at frame start still aborts; pin is inert without the lock
      if (wp_fall && pin_lock && (!cs_stable || frame_start))
        wp_abort <= 1'b1;                                                 // RL21
      else if (frame_start)
        wp_abort <= 1'b0;
      array_write_allowed <= write_enable_latch & ~addr_protected;        // RL19
      nv_value <= {pin_lock, protect};
    end
  end

  // Link domain: frame reset is the deselect itself
  wire link_rst_n = reset_n & ~cs_n;

  logic [2:0] bit_idx;
  logic [1:0] byte_cnt;
  logic [6:0] shift_in;
  logic       read_active;
  logic [7:0] tx_word;
  logic [7:0] status_meta;
  logic [7:0] status_sync;

  wire [7:0] rx_byte      = {shift_in, si};
  wire       opcode_done  = (byte_cnt == BYTE_OPCODE) & (bit_idx == LAST_BIT);
  wire       data_done    = (byte_cnt == BYTE_DATA) & (bit_idx == LAST_BIT);
  wire       first_bit    = (byte_cnt == BYTE_OPCODE) & (bit_idx == 3'h0);
  wire       overrun      = (byte_cnt == BYTE_OVERRUN) & (bit_idx == 3'h0);

  function automatic link_cmd_e decode(input logic [7:0] op);
    logic [7:0] m;
    m = op & OPCODE_MASK;                                                 // RL20
    if (m == OPC_SET_LATCH)         decode = CMD_SET_LATCH;
    else if (m == OPC_CLEAR_LATCH)  decode = CMD_CLEAR_LATCH;
    else if (m == OPC_READ_STATUS)  decode = CMD_READ_STATUS;
    else if (m == OPC_WRITE_STATUS) decode = CMD_WRITE_STATUS;
    else if (m == OPC_READ_ARRAY)   decode = CMD_READ_ARRAY;
    else if (m == OPC_WRITE_ARRAY)  decode = CMD_WRITE_ARRAY;
    else                            decode = CMD_INVALID;
  endfunction

  always_ff @(posedge sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_idx     <= 3'h0;
      byte_cnt    <= 2'h0;
      shift_in    <= 7'h0;
      read_active <= 1'b0;
    end
    else
    begin
      bit_idx  <= bit_idx + 3'h1;
      shift_in <= rx_byte[6:0];
      if (bit_idx == LAST_BIT && byte_cnt != 2'h3)
        byte_cnt <= byte_cnt + 2'h1;
      if (opcode_done)
        read_active <= (decode(rx_byte) == CMD_READ_STATUS);              // RL7
    end
  end

  // Status is quasi-static; eight opcode edges refresh the sync pair before use
  always_ff @(posedge sck or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_meta <= 8'h0;
      status_sync <= 8'h0;
      tx_word     <= 8'h0;
      frame       <= '{cmd: CMD_NONE, data: 8'h0, length_ok: 1'b0};
    end
    else
    begin
      status_meta <= status_word;
      status_sync <= status_meta;
      if (first_bit)
      begin
        frame.cmd       <= CMD_NONE;
        frame.length_ok <= 1'b0;
      end
      if (opcode_done)
      begin
        frame.cmd <= decode(rx_byte);
        tx_word   <= status_sync;                                         // RL7
      end
      if (data_done)
      begin
        frame.data      <= rx_byte;
        frame.length_ok <= 1'b1;
      end
      else if (overrun)
        frame.length_ok <= 1'b0;
    end
  end

  // Output changes on the falling edge, MSB first, repeats while clocked
  always_ff @(negedge sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      so_oe  <= 1'b0;
      so_out <= 1'b0;
    end
    else
    begin
      so_oe  <= read_active;                                              // RL7
      so_out <= tx_word[~bit_idx];
    end
  end

  // Checks
  int unsigned busy_len;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      busy_len <= 0;
    else
      busy_len <= busy ? busy_len + 1 : 0;
  end

  property p_reserved_follow;                                             // RL2
    @(posedge clk) disable iff (!reset_n)
      busy |-> (status_word[6:4] == 3'h7) ##1 (busy || status_word[6:4] == 3'h0);
  endproperty
  a_reserved_follow: assert property (p_reserved_follow) else $error("reserved bits wrong");

  property p_busy_length;                                                 // RL23
    @(posedge clk) disable iff (!reset_n)
      $fell(busy) |-> busy_len == WRITE_CYCLES;
  endproperty
  a_busy_length: assert property (p_busy_length) else $error("busy length wrong");

  property p_latch_cleared_at_end;                                        // RL15
    @(posedge clk) disable iff (!reset_n)
      $fell(busy) |-> !write_enable_latch;
  endproperty
  a_latch_cleared_at_end: assert property (p_latch_cleared_at_end) else $error("latch kept");

  property p_lock_held;                                                   // RL18
    @(posedge clk) disable iff (!reset_n)
      (nv_loaded && pin_lock && !wp_stable) |=> pin_lock;
  endproperty
  a_lock_held: assert property (p_lock_held) else $error("lock cleared under guard");

  property p_guard_refuses;                                               // RL16
    @(posedge clk) disable iff (!reset_n)
      (take_cmd && frame.cmd == CMD_WRITE_STATUS && hw_protect) |=> !busy && $stable(nv_value);
  endproperty
  a_guard_refuses: assert property (p_guard_refuses) else $error("guarded write taken");

  property p_no_latch_no_write;                                           // RL22
    @(posedge clk) disable iff (!reset_n)
      (take_cmd && frame.cmd == CMD_WRITE_STATUS && !write_enable_latch)
        |=> !busy ##1 $stable(nv_value);
  endproperty
  a_no_latch_no_write: assert property (p_no_latch_no_write) else $error("write without latch");

  property p_write_starts_cycle;                                          // RL13
    @(posedge clk) disable iff (!reset_n)
      (take_cmd && frame.cmd == CMD_WRITE_STATUS && frame.length_ok && write_enable_latch
       && !hw_protect && !wp_abort) |=> busy ##1 (nv_value == {frame.data[7], frame.data[3:2]});
  endproperty
  a_write_starts_cycle: assert property (p_write_starts_cycle) else $error("cycle not started");

  property p_set_latch;                                                   // RL8
    @(posedge clk) disable iff (!reset_n)
      (take_cmd && frame.cmd == CMD_SET_LATCH) |=> write_enable_latch;
  endproperty
  a_set_latch: assert property (p_set_latch) else $error("latch not set");

  property p_clear_latch;                                                 // RL10
    @(posedge clk) disable iff (!reset_n)
      (take_cmd && frame.cmd == CMD_CLEAR_LATCH) |=> !write_enable_latch;
  endproperty
  a_clear_latch: assert property (p_clear_latch) else $error("latch not cleared");

  property p_busy_ignores;                                                // RL14
    @(posedge clk) disable iff (!reset_n)
      (frame_end && busy && timer != 24'h0) |=> $stable(write_enable_latch) && busy;
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("command taken while busy");

  property p_array_guard;                                                 // RL19
    @(posedge clk) disable iff (!reset_n)
      (addr_protected || !write_enable_latch) |=> !array_write_allowed;
  endproperty
  a_array_guard: assert property (p_array_guard) else $error("protected address allowed");

  c_status_write: cover property (@(posedge clk) disable iff (!reset_n) write_ok ##1 busy);
  c_cycle_end: cover property (@(posedge clk) disable iff (!reset_n) cycle_done);
  c_guard_refuse: cover property (@(posedge clk) disable iff (!reset_n)
    take_cmd && frame.cmd == CMD_WRITE_STATUS && hw_protect);
  c_status_read: cover property (@(negedge sck) disable iff (!link_rst_n) so_oe);

endmodule

`default_nettype wire

/* File: spi_host_model.sv */
// Purpose: SPI mode 0 host model for the EEPROM status link
// Assumes: 64 ns serial clock, phase unrelated to the system clock
// Notes:   Serial clock stands low outside frames
`default_nettype none

module spi_host_model (
  output var  logic sck,    // Serial clock
  output var  logic cs_n,   // Chip select
  output var  logic si,     // Serial data to device
  input  wire logic so_out, // Serial data from device
  input  wire logic so_oe   // Device drives data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic so_last;
  logic so_line;

  // Released line flips so a stale bit never passes
  always_comb so_line = so_oe ? so_out : ~so_last;
  always @(posedge sck) so_last <= so_line;

  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    so_last = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    #1.3;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      si = tx[15 - i];
      #32;
      sck = 1'b1;
      if (i >= 8)
        rx = {rx[6:0], so_line};
      #32;
      sck = 1'b0;
    end
    #16;
    cs_n = 1'b1;
    si = ~si;
    // Gap long enough for the system side to see the end
    #40;
  endtask
endmodule

`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the EEPROM status and protect block
// Assumes: Short internal write cycle for simulation
// Notes:   Status is judged through status-read frames and the nv_value and array_write_allowed outputs
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import eeprom_status_pkg::*;
  localparam int CYCLES = 1000;
  logic        clk, reset_n, sck, cs_n, si, wp_n, so_out, so_oe, array_write_allowed;
  logic [15:0] array_addr;
  logic [2:0]  nv_load_value, nv_value;
  logic [7:0]  rx;
  logic [15:0] addrs [6] = '{16'h0000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hffff};
  int          err_total, tests_run;

  eeprom_status_protect #(.WRITE_CYCLES(CYCLES)) eeprom_status_protect_i (
    .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so_out(so_out), .so_oe(so_oe), .array_addr(array_addr),
    .array_write_allowed(array_write_allowed), .nv_load_value(nv_load_value),
    .nv_value(nv_value));

  spi_host_model spi_host_model_i (
    .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe));

  always #2 clk = ~clk;

  function automatic logic [7:0] stat(logic lock, logic [1:0] bp, logic latch, logic busy);
    return {lock, {3{busy}}, bp, latch, busy};
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    spi_host_model_i.xfer({op, 8'h00}, 8, rx);
  endtask

  task automatic wr(input logic [7:0] d);
    spi_host_model_i.xfer({OPC_WRITE_STATUS, d}, 16, rx);
  endtask

  task automatic rd_check(input string what, input logic [7:0] exp);
    spi_host_model_i.xfer({OPC_READ_STATUS, 8'h00}, 16, rx);
    check(what, exp, rx);
  endtask

  task automatic set_guard(input logic v);
    @(posedge clk);
    wp_n <= v;
  endtask

  // Polls like firmware would; bounded so a stuck flag ends the run
  task automatic wait_ready;
    for (int n = 0; n < 10; n++)
    begin
      spi_host_model_i.xfer({OPC_READ_STATUS, 8'h00}, 16, rx);
      if (rx[0] === 1'b0)
        return;
    end
    err_total++;
    $display("Error ready flag expected 0 seen %h", rx[0]);
    stop_test();
  endtask

  task automatic t_latch;
    cmd(OPC_SET_LATCH | 8'h08);
    cmd(OPC_WRITE_ARRAY);
    cmd(8'hff);
    rd_check("status after set", stat(1'b1, 2'b01, 1'b1, 1'b0));
    set_guard(1'b0);
    cmd(OPC_CLEAR_LATCH);
    spi_host_model_i.xfer({8'h0d, 8'h00}, 16, rx);
    check("status after clear", stat(1'b1, 2'b01, 1'b0, 1'b0), rx);
    set_guard(1'b1);
  endtask

  task automatic t_levels;
    for (int l = 3; l >= 0; l--)
    begin
      cmd(OPC_SET_LATCH);
      wr({4'h0, l[1:0], 2'h0});
      wait_ready();
      rd_check("level status", stat(1'b0, l[1:0], 1'b0, 1'b0));
      check("stored bits", {5'h0, 1'b0, l[1:0]}, {5'h0, nv_value});
      cmd(OPC_SET_LATCH);
      foreach (addrs[k])
      begin
        @(posedge clk);
        array_addr <= addrs[k];
        repeat (2) @(posedge clk);
        #1;
        check("write allowed", {7'h0, !((l == 3) || (l == 2 && addrs[k][15])
          || (l == 1 && addrs[k][15:14] == 2'b11))}, {7'h0, array_write_allowed});
      end
    end
    cmd(OPC_CLEAR_LATCH);
    repeat (2) @(posedge clk);
    #1;
    check("write without latch", 8'h00, {7'h0, array_write_allowed});
  endtask

  task automatic t_busy;
    cmd(OPC_SET_LATCH);
    wr(8'hff);
    rd_check("busy bits", 8'hff);
    wr(8'h00);
    wait_ready();
    rd_check("after cycle", stat(1'b1, 2'b11, 1'b0, 1'b0));
  endtask

  task automatic t_guard;
    set_guard(1'b0);
    cmd(OPC_SET_LATCH);
    wr(8'h00);
    rd_check("guarded", stat(1'b1, 2'b11, 1'b1, 1'b0));
    check("guarded bits", 8'h07, {5'h0, nv_value});
    set_guard(1'b1);
    fork
      wr(8'h00);
      begin
        repeat (100) @(posedge clk);
        wp_n <= 1'b0;
        repeat (20) @(posedge clk);
        wp_n <= 1'b1;
      end
    join
    rd_check("aborted", stat(1'b1, 2'b11, 1'b1, 1'b0));
    cmd(OPC_SET_LATCH);
    wr(8'h00);
    wait_ready();
    rd_check("unguarded", 8'h00);
    wr(8'h0c);
    rd_check("no latch write", 8'h00);
  endtask

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    wp_n = 1'b1;
    array_addr = 16'h0000;
    nv_load_value = 3'h5;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    check("bits in reset", 8'h00, {5'h0, nv_value});
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    check("loaded bits", 8'h05, {5'h0, nv_value});
    rd_check("power-up status", stat(1'b1, 2'b01, 1'b0, 1'b0));
    t_latch();
    t_levels();
    t_busy();
    t_guard();
    stop_test();
  end
endmodule

`default_nettype wire
